/* File: bench/capture_link_props.sv */
// Checker watching the pins between controller and device ends
`timescale 1ns/1ns
`default_nettype none
`include "capture_defines.svh"
module capture_link_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link pins
  input wire logic inClk,
  input wire logic selectN,
  input wire logic writeCmdN,
  input wire logic refreshCmdN,
  input wire logic [`LOC_W-1:0] location_inputs,
  input wire logic [1:0] write_capture_clk,
  input wire logic [1:0] write_capture_clk_inv,
  input wire logic [`DATA_W-1:0] dataIn,
  input wire logic write_mask
);
  // ****************************************
  // Settling counter
  // ****************************************
  // Divider phase is reset to zero with the controller, and rules other than p_upper_zero start once settled
  logic [3:0] age;
  logic [3:0] next_age;
  logic settled;
  always_comb next_age = rst ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
  always_ff @(posedge clk) age <= next_age;
  assign settled = (age == 4'hF);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Properties
  // ****************************************
  property p_inclk_half;
    settled && $rose(inClk) |-> inClk[*6] ##1 !inClk;
  endproperty
  property p_dk_runs;
    settled |-> ##[0:11] $changed(write_capture_clk[0]);
  endproperty
  property p_dk_compl;
    settled |-> write_capture_clk_inv == ~write_capture_clk;
  endproperty
  property p_sel_period;
    settled && $changed(selectN) |-> $fell(inClk);
  endproperty
  property p_upper_zero;
    location_inputs[`LOC_W-1:`LOC_W-2] == 2'h0;
  endproperty
  property p_write_beats;
    settled && $fell(writeCmdN) && refreshCmdN |-> ##[1:24] $changed(dataIn);
  endproperty
  property p_mask_idle;
    settled && writeCmdN |-> write_mask;
  endproperty
  property p_data_steady;
    settled && $changed(write_capture_clk) |-> $stable(dataIn)[*3];
  endproperty
  a_inclk_half: assert property (p_inclk_half) else $error("link clock half period wrong");
  a_dk_runs: assert property (p_dk_runs) else $error("data clock stopped");
  a_dk_compl: assert property (p_dk_compl) else $error("data clock pair not complementary");
  a_sel_period: assert property (p_sel_period) else $error("select moved off a link clock fall");
  a_upper_zero: assert property (p_upper_zero) else $error("upper location bits driven");
  a_write_beats: assert property (p_write_beats) else $error("second beat missing");
  a_mask_idle: assert property (p_mask_idle) else $error("mask low outside write");
  a_data_steady: assert property (p_data_steady) else $error("data moved at clock edge");
  c_write: cover property ($fell(writeCmdN) && refreshCmdN);
  c_read: cover property (!selectN && !writeCmdN && !refreshCmdN);
  c_cfg: cover property (!selectN && writeCmdN && !refreshCmdN);
endmodule : capture_link_props
`default_nettype wire

/* File: bench/test_cmd_addr_data_capture.sv */
// Bench joining controller end and device end over the link
`timescale 1ns/1ns
`default_nettype none
`include "capture_defines.svh"
module test_cmd_addr_data_capture;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid, reqReady, cmdValid, busy, beatValid, beatReady, overflow;
  logic [`LOC_W-1:0] reqLocation, cmdLocation, cfgValue;
  logic [`BANK_W-1:0] reqBank, cmdBank;
  logic [`DATA_W-1:0] reqData0, reqData1, beatData;
  logic [1:0] reqMask;
  capture_pkg::cmd_t reqCmd, cmdCode;
  capture_pkg::width_t widthMode;
  logic [`DATA_W-1:0] expq[$];
  int n_fail = 0;
  int comparisons = 0;
  int i;
  // ****************************************
  // Design and checker
  // ****************************************
  capture_link_if link ();
  ctrl_drive ctrl_drive_i (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd),
    .reqLocation(reqLocation), .reqBank(reqBank), .reqData0(reqData0), .reqData1(reqData1),
    .reqMask(reqMask), .link(link.ctrl));
  mem_capture mem_capture_i (.clk(clk), .rst(rst), .widthMode(widthMode), .link(link.mem),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdLocation(cmdLocation), .cmdBank(cmdBank),
    .cfgValue(cfgValue), .busy(busy), .beatValid(beatValid), .beatReady(beatReady), .beatData(beatData),
    .overflow(overflow));
  capture_link_props capture_link_props_i (.clk(clk), .rst(rst), .inClk(link.inClk), .selectN(link.selectN),
    .writeCmdN(link.writeCmdN), .refreshCmdN(link.refreshCmdN), .location_inputs(link.location_inputs),
    .write_capture_clk(link.write_capture_clk), .write_capture_clk_inv(link.write_capture_clk_inv),
    .dataIn(link.dataIn), .write_mask(link.write_mask));
  always #2 clk = ~clk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk_val(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_cmd(input capture_pkg::cmd_t got, input capture_pkg::cmd_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cmd
  task automatic send(input capture_pkg::cmd_t c, input logic [`LOC_W-1:0] loc, input logic [1:0] m);
    int k;
    logic [`LOC_W-1:0] exp;
    exp = loc & 22'h0FFFFF;
    @(negedge clk);
    reqCmd = c;
    reqLocation = loc;
    reqBank = loc[2:0];
    reqMask = m;
    reqData0 = {loc[13:0], loc};
    reqData1 = ~{loc[13:0], loc};
    reqValid = 1'b1;
    // Ready is a one-cycle pulse, so look just after each falling edge
    #1;
    k = 0;
    while (reqReady !== 1'b1 && k < 100) begin
      @(negedge clk);
      #1;
      k++;
    end
    @(negedge clk);
    reqValid = 1'b0;
    k = 0;
    while (cmdValid !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk_val(36'(cmdValid), 36'h1);
    chk_cmd(cmdCode, c);
    chk_val(36'(busy), 36'h1);
    if (c == capture_pkg::CMD_LOAD_CFG) begin
      chk_val(36'(cfgValue), 36'(exp));
    end else begin
      chk_val(36'(cmdLocation), 36'(exp));
      chk_val(36'(cmdBank), 36'(loc[2:0]));
    end
    if (c == capture_pkg::CMD_WRITE && !m[0]) expq.push_back({loc[13:0], loc});
    if (c == capture_pkg::CMD_WRITE && !m[1]) expq.push_back(~{loc[13:0], loc});
    // Select is high at the next link clock rise, so nothing new may decode
    k = 0;
    repeat (24) begin
      @(negedge clk);
      if (cmdValid === 1'b1) k++;
    end
    chk_val(36'(k), 36'h0);
    chk_val(36'(busy), 36'h0);
  endtask : send
  task automatic drain();
    int k;
    while (expq.size() > 0) begin
      k = 0;
      while (beatValid !== 1'b1 && k < 200) begin
        @(negedge clk);
        k++;
      end
      chk_val(36'(beatValid), 36'h1);
      chk_val(beatData, expq.pop_front());
      beatReady = 1'b1;
      @(negedge clk);
      beatReady = 1'b0;
    end
  endtask : drain
  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    widthMode = capture_pkg::WIDTH_X36;
    beatReady = 1'b0;
    reqValid = 1'b0;
    reqCmd = capture_pkg::CMD_NOP;
    reqLocation = 22'h0;
    reqBank = 3'h0;
    reqData0 = 36'h0;
    reqData1 = 36'h0;
    reqMask = 2'h0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    // Every mask pattern while the drain side stalls
    for (i = 0; i < 4; i++) send(capture_pkg::CMD_WRITE, 22'h3FFFF0 + 22'(i), 2'(i));
    send(capture_pkg::CMD_READ, 22'h2ABCDE, 2'h0);
    send(capture_pkg::CMD_LOAD_CFG, 22'h1F00AA, 2'h0);
    send(capture_pkg::CMD_WRITE, 22'h12345, 2'h0);
    send(capture_pkg::CMD_WRITE, 22'h2C3D5, 2'h0);
    // Ninth and tenth words find the buffer full and are lost
    send(capture_pkg::CMD_WRITE, 22'h0F0F0, 2'h0);
    expq = expq[0:7];
    repeat (40) @(negedge clk);
    chk_val(36'(overflow), 36'h1);
    drain();
    chk_val(36'(beatValid), 36'h0);
    widthMode = capture_pkg::WIDTH_X18;
    send(capture_pkg::CMD_WRITE, 22'h13579, 2'h0);
    drain();
    widthMode = capture_pkg::WIDTH_X9;
    send(capture_pkg::CMD_WRITE, 22'h2468A, 2'h1);
    drain();
    give_verdict();
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule : test_cmd_addr_data_capture
`default_nettype wire

/* File: verilog/capture_defines.svh */
// Constants for the command, address and write-data capture link
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH
`define LOC_W 22
`define BANK_W 3
`define DATA_W 36
`define HALF_W 18
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define DIV_HALF 3'h5
`define DK_PHASE 3'h2
`define OP_HOLD 4'hF
`endif

/* File: verilog/capture_link_if.sv */
// Pin-level link between controller and memory device
`timescale 1ns/1ns
`default_nettype none
`include "capture_defines.svh"
interface capture_link_if;
  logic inClk;
  logic selectN;
  logic writeCmdN;
  logic refreshCmdN;
  logic [`LOC_W-1:0] location_inputs;
  logic [`BANK_W-1:0] bank_select_inputs;
  logic [1:0] write_capture_clk;
  logic [1:0] write_capture_clk_inv;
  logic [`DATA_W-1:0] dataIn;
  logic write_mask;
  modport ctrl (output inClk, selectN, writeCmdN, refreshCmdN, location_inputs, bank_select_inputs,
    write_capture_clk, write_capture_clk_inv, dataIn, write_mask);
  modport mem (input inClk, selectN, writeCmdN, refreshCmdN, location_inputs, bank_select_inputs,
    write_capture_clk, write_capture_clk_inv, dataIn, write_mask);
endinterface : capture_link_if
`default_nettype wire

/* File: verilog/capture_pkg.sv */
// Types shared by the capture link ends
`default_nettype none
`include "capture_defines.svh"
package capture_pkg;
  typedef enum logic [1:0] {CMD_NOP = 2'h0, CMD_WRITE = 2'h1, CMD_READ = 2'h3, CMD_LOAD_CFG = 2'h2} cmd_t;
  typedef enum logic [1:0] {WIDTH_X9 = 2'h0, WIDTH_X18 = 2'h1, WIDTH_X36 = 2'h3} width_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_CMD = 2'h1, ST_BEAT0 = 2'h3, ST_BEAT1 = 2'h2} host_state_t;
endpackage : capture_pkg
`default_nettype wire

/* File: verilog/ctrl_drive.sv */
// Controller end: drives commands, location and DDR write data
`timescale 1ns/1ns
`default_nettype none
`include "capture_defines.svh"
module ctrl_drive (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic reqValid,
  output logic reqReady,
  input wire capture_pkg::cmd_t reqCmd,
  input wire logic [`LOC_W-1:0] reqLocation,
  input wire logic [`BANK_W-1:0] reqBank,
  input wire logic [`DATA_W-1:0] reqData0,
  input wire logic [`DATA_W-1:0] reqData1,
  input wire logic [1:0] reqMask,
  // Link
  capture_link_if.ctrl link
);
  // ****************************************
  // Clock divider
  // ****************************************
  logic [2:0] div, next_div;
  logic clkLevel, next_clkLevel, tick;
  assign tick = div == `DIV_HALF;
  always_comb begin
    next_div = tick ? 3'h0 : div + 3'h1;
    next_clkLevel = tick ? ~clkLevel : clkLevel;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      div <= 3'h0;
      clkLevel <= 1'b0;
    end else begin
      div <= next_div;
      clkLevel <= next_clkLevel;
    end
  end
  // Data clocks run always, shifted half a phase from data changes
  logic dkLevel, next_dkLevel;
  assign next_dkLevel = (div == `DK_PHASE) ? ~clkLevel : dkLevel;
  always_ff @(posedge clk) begin
    if (rst) begin
      dkLevel <= 1'b0;
    end else begin
      dkLevel <= next_dkLevel;
    end
  end
  assign link.inClk = clkLevel;
  assign link.write_capture_clk = {dkLevel, dkLevel};
  assign link.write_capture_clk_inv = {~dkLevel, ~dkLevel};
  // ****************************************
  // Sequencer
  // ****************************************
  capture_pkg::host_state_t st, next_st;
  logic selN, weN, refN, msk, next_selN, next_weN, next_refN, next_msk;
  logic [`LOC_W-1:0] loc, next_loc;
  logic [`BANK_W-1:0] bank, next_bank;
  logic [`DATA_W-1:0] dat, next_dat, d1, next_d1;
  logic m0, next_m0, m1, next_m1;
  logic fall, rise;
  assign fall = tick && clkLevel;
  assign rise = tick && !clkLevel;
  assign reqReady = (st == capture_pkg::ST_IDLE) && fall;
  always_comb begin
    next_st = st;
    next_selN = selN;
    next_weN = weN;
    next_refN = refN;
    next_msk = msk;
    next_loc = loc;
    next_bank = bank;
    next_dat = dat;
    next_d1 = d1;
    next_m1 = m1;
    next_m0 = m0;
    case (st)
      capture_pkg::ST_IDLE: begin
        if (fall) begin
          next_selN = 1'b1;
          next_weN = 1'b1;
          next_refN = 1'b1;
          if (reqValid) begin
            next_selN = 1'b0;
            next_weN = !reqCmd[0];
            next_refN = !reqCmd[1];
            next_loc = reqLocation;
            next_loc[`LOC_W-1:`LOC_W-2] = 2'h0;
            next_bank = reqBank;
            next_dat = reqData0;
            // Beat zero stays masked until the command period is over
            next_m0 = reqMask[0];
            next_d1 = reqData1;
            next_m1 = reqMask[1];
            next_st = (reqCmd == capture_pkg::CMD_WRITE) ? capture_pkg::ST_CMD : capture_pkg::ST_IDLE;
          end
        end
      end
      capture_pkg::ST_CMD: begin
        if (fall) begin
          next_selN = 1'b1;
          next_msk = m0;
          next_st = capture_pkg::ST_BEAT0;
        end
      end
      capture_pkg::ST_BEAT0: begin
        if (rise) begin
          next_dat = d1;
          next_msk = m1;
          next_st = capture_pkg::ST_BEAT1;
        end
      end
      default: begin
        if (fall) begin
          next_weN = 1'b1;
          next_msk = 1'b1;
          next_st = capture_pkg::ST_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= capture_pkg::ST_IDLE;
      selN <= 1'b1;
      weN <= 1'b1;
      refN <= 1'b1;
      msk <= 1'b1;
      loc <= '0;
      bank <= '0;
      dat <= '0;
      d1 <= '0;
      m1 <= 1'b1;
      m0 <= 1'b1;
    end else begin
      st <= next_st;
      selN <= next_selN;
      weN <= next_weN;
      refN <= next_refN;
      msk <= next_msk;
      loc <= next_loc;
      bank <= next_bank;
      dat <= next_dat;
      d1 <= next_d1;
      m1 <= next_m1;
      m0 <= next_m0;
    end
  end
  assign link.selectN = selN;
  assign link.writeCmdN = weN;
  assign link.refreshCmdN = refN;
  assign link.location_inputs = loc;
  assign link.bank_select_inputs = bank;
  assign link.dataIn = dat;
  assign link.write_mask = msk;
endmodule : ctrl_drive
`default_nettype wire

/* File: verilog/mem_capture.sv */
// Memory device end: command, address and DDR write-data capture
`timescale 1ns/1ns
`default_nettype none
`include "capture_defines.svh"
module mem_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire capture_pkg::width_t widthMode,
  // Link
  capture_link_if.mem link,
  // Decoded command out
  output logic cmdValid,
  output capture_pkg::cmd_t cmdCode,
  output logic [`LOC_W-1:0] cmdLocation,
  output logic [`BANK_W-1:0] cmdBank,
  output logic [`LOC_W-1:0] cfgValue,
  output logic busy,
  // Captured write data out
  output logic beatValid,
  input wire logic beatReady,
  output logic [`DATA_W-1:0] beatData,
  output logic overflow
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  // Strobes, location and data share the clock's latency so they stay aligned
  logic ckS1, ckS2, ckS3;
  logic [1:0] dkS1, dkS2, dkS3, dkiS1, dkiS2, dkiS3;
  logic [4:0] cS1, cS2;
  logic [`LOC_W-1:0] locS1, locS2;
  logic [`BANK_W-1:0] bankS1, bankS2;
  logic [`DATA_W-1:0] datS1, datS2;
  always_ff @(posedge clk) begin
    ckS1 <= link.inClk;
    ckS2 <= ckS1;
    ckS3 <= ckS2;
    dkS1 <= link.write_capture_clk;
    dkS2 <= dkS1;
    dkS3 <= dkS2;
    dkiS1 <= link.write_capture_clk_inv;
    dkiS2 <= dkiS1;
    dkiS3 <= dkiS2;
    cS1 <= {link.selectN, link.writeCmdN, link.refreshCmdN, link.write_mask, 1'b0};
    cS2 <= cS1;
    locS1 <= link.location_inputs;
    locS2 <= locS1;
    bankS1 <= link.bank_select_inputs;
    bankS2 <= bankS1;
    datS1 <= link.dataIn;
    datS2 <= datS1;
  end
  logic ckRise;
  logic [1:0] dkEdge;
  assign ckRise = ckS2 && !ckS3;
  // Either edge of the true or complement phase marks a beat
  assign dkEdge = (dkS2 ^ dkS3) | (dkiS2 ^ dkiS3);
  // ****************************************
  // Pin command decode
  // ****************************************
  // Strobes are active low; both low together is a read
  capture_pkg::cmd_t pinCmd;
  always_comb begin
    if (!cS2[3] && !cS2[2]) begin
      pinCmd = capture_pkg::CMD_READ;
    end else if (!cS2[3]) begin
      pinCmd = capture_pkg::CMD_WRITE;
    end else if (!cS2[2]) begin
      pinCmd = capture_pkg::CMD_LOAD_CFG;
    end else begin
      pinCmd = capture_pkg::CMD_NOP;
    end
  end
  // ****************************************
  // Command decode
  // ****************************************
  logic next_cmdValid;
  capture_pkg::cmd_t next_cmdCode;
  logic [`LOC_W-1:0] next_cmdLocation, next_cfgValue, locMasked;
  logic [`BANK_W-1:0] next_cmdBank;
  logic [3:0] opCount, next_opCount;
  always_comb begin
    locMasked = locS2;
    // Reserved upper lines carry no function in the widest mode
    if (widthMode == capture_pkg::WIDTH_X36) begin
      locMasked[`LOC_W-1:`LOC_W-2] = 2'h0;
    end
    next_cmdValid = 1'b0;
    next_cmdCode = cmdCode;
    next_cmdLocation = cmdLocation;
    next_cmdBank = cmdBank;
    next_cfgValue = cfgValue;
    next_opCount = (opCount != 4'h0) ? opCount - 4'h1 : 4'h0;
    // Deselected cycles leave the op counter running down
    if (ckRise && !cS2[4] && pinCmd != capture_pkg::CMD_NOP) begin
      next_cmdCode = pinCmd;
      next_cmdValid = 1'b1;
      next_cmdBank = bankS2;
      next_opCount = `OP_HOLD;
      if (pinCmd == capture_pkg::CMD_LOAD_CFG) begin
        next_cfgValue = locMasked;
      end else begin
        next_cmdLocation = locMasked;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdValid <= 1'b0;
      cmdCode <= capture_pkg::CMD_NOP;
      cmdLocation <= '0;
      cmdBank <= '0;
      cfgValue <= '0;
      opCount <= 4'h0;
    end else begin
      cmdValid <= next_cmdValid;
      cmdCode <= next_cmdCode;
      cmdLocation <= next_cmdLocation;
      cmdBank <= next_cmdBank;
      cfgValue <= next_cfgValue;
      opCount <= next_opCount;
    end
  end
  // ****************************************
  // Status
  // ****************************************
  assign busy = opCount != 4'h0;
  // ****************************************
  // Write data capture
  // ****************************************
  logic [`DATA_W-1:0] word, next_word;
  logic [1:0] have, next_have;
  logic push, next_push, next_overflow, pushReady;
  logic [1:0] needHalves;
  always_comb begin
    next_word = word;
    next_have = have;
    next_push = 1'b0;
    next_overflow = overflow;
    needHalves = (widthMode == capture_pkg::WIDTH_X36) ? 2'h3 : 2'h1;
    // One mask covers both halves, so a word arrives whole or not at all
    if (widthMode == capture_pkg::WIDTH_X36) begin
      if (dkEdge[0] && !cS2[1]) begin
        next_word[`HALF_W-1:0] = datS2[`HALF_W-1:0];
        next_have[0] = 1'b1;
      end
      // Upper half follows the upper clock, under the same mask, in the widest mode
      if (dkEdge[1] && !cS2[1]) begin
        next_word[`DATA_W-1:`HALF_W] = datS2[`DATA_W-1:`HALF_W];
        next_have[1] = 1'b1;
      end
    end else if (dkEdge[0] && !cS2[1]) begin
      next_word = datS2;
      next_have = 2'h1;
    end
    // A completed word enters the buffer on the following cycle
    if (next_have == needHalves) begin
      next_push = 1'b1;
      next_have = 2'h0;
      if (!pushReady) begin
        next_overflow = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      word <= '0;
      have <= 2'h0;
      push <= 1'b0;
      overflow <= 1'b0;
    end else begin
      word <= next_word;
      have <= next_have;
      push <= next_push;
      overflow <= next_overflow;
    end
  end
  // Beats cannot be paused on the pins; a full FIFO is flagged sticky
  word_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) dataFifo (
    .clk(clk),
    .rst(rst),
    .inValid(push),
    .inReady(pushReady),
    .inData(word),
    .outValid(beatValid),
    .outReady(beatReady),
    .outData(beatData)
  );
endmodule : mem_capture
`default_nettype wire

/* File: verilog/word_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic doWr, doRd;
  assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  always_comb begin
    next_wrPtr = wrPtr + (AW+1)'(doWr);
    next_rdPtr = rdPtr + (AW+1)'(doRd);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule : word_fifo
`default_nettype wire
